// ---- rtl/modem_host_register_port.sv ----
// Host register port: parallel muxed bus and strapped serial mode
`timescale 1ns/10ps

// Overview of operation
// - Parallel write captured on write strobe rise
// - Parallel write needs strobe low, latched select
// - Serial bits move on bit clock falls
// - Data line output while read low
// - Read strobe fall starts serial read
// - Serial read shifts least significant first
// - Serial byte stored on write strobe rise
// - Latch high, select low means serial
// - Top line data, low three lines select
// - Sample transmit data on bit clock rise
// - Bit clock serves control and transmit timing
// - Address and select latched on latch fall
// - Codes zero to three pick four registers
// - Detect register ignores writes
// - Parallel bus driven only during valid reads
module modem_host_register_port (
  input wire logic mclk,
  input wire logic rst,
  input wire logic external_bit_clock,
  input wire modem_port_pkg::strobes_t strobes,
  input wire logic [7:0] muxed_addr_data_bus_in,
  output logic [7:0] muxed_addr_data_bus_out_r,
  output logic [7:0] muxed_addr_data_bus_oe_r,
  input wire logic [7:0] detect_status,
  input wire logic ext_timing_sel,
  input wire logic tx_data_in,
  output logic tx_bit_r,
  output logic tx_bit_valid_r,
  output logic serial_mode_r,
  output logic [7:0] control_reg_zero_r,
  output logic [7:0] control_reg_one_r,
  output logic [7:0] tone_setup_reg_r
);

  // ---------------- Link domain (external bit clock) ----------------

  logic lrst_s1_r;
  logic lrst_r;
  logic [7:0] ser_shift_r;
  logic fall_tgl_r;
  logic rise_tgl_r;
  logic [1:0] tx_slot_r;

  // Reset brought over to the link clock; a stopped clock just delays it
  always_ff @(posedge external_bit_clock) begin
    lrst_s1_r <= rst;
    lrst_r <= lrst_s1_r;
  end

  // Serial shift in on every falling edge, newest bit enters at the top
  always_ff @(negedge external_bit_clock) begin
    if (lrst_r) begin
      ser_shift_r <= modem_port_pkg::BYTE_ZERO;
      fall_tgl_r <= 1'b0;
    end else begin
      ser_shift_r <= {muxed_addr_data_bus_in[modem_port_pkg::SDATA_BIT],
                      ser_shift_r[7:1]};
      fall_tgl_r <= ~fall_tgl_r;
    end
  end

  // Transmit data on rising edges, ping-pong slots so mclk has two periods
  always_ff @(posedge external_bit_clock) begin
    if (lrst_r) begin
      tx_slot_r <= 2'b00;
      rise_tgl_r <= 1'b0;
    end else begin
      tx_slot_r[rise_tgl_r] <= tx_data_in;
      rise_tgl_r <= ~rise_tgl_r;
    end
  end

  // ---------------- Host clock domain ----------------

  // Pin synchronisers; stage one is read only by stage two
  logic [3:0] stb_s1_r;
  logic [3:0] stb_s2_r;
  logic [3:0] stb_d_r;
  logic [7:0] bus_s1_r;
  logic [7:0] bus_s2_r;
  logic [7:0] bus_d_r;
  logic fall_s1_r;
  logic fall_s2_r;
  logic fall_d_r;
  logic rise_s1_r;
  logic rise_s2_r;
  logic rise_d_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Parallel idle pin levels, so no false latch edge follows reset
      stb_s1_r <= 4'h7;
      stb_s2_r <= 4'h7;
      stb_d_r <= 4'h7;
      bus_s1_r <= modem_port_pkg::BYTE_ZERO;
      bus_s2_r <= modem_port_pkg::BYTE_ZERO;
      bus_d_r <= modem_port_pkg::BYTE_ZERO;
    end else begin
      stb_s1_r <= strobes;
      stb_s2_r <= stb_s1_r;
      stb_d_r <= stb_s2_r;
      bus_s1_r <= muxed_addr_data_bus_in;
      bus_s2_r <= bus_s1_r;
      bus_d_r <= bus_s2_r;
    end
  end

  // Toggle event synchronisers from the link domain
  always_ff @(posedge mclk) begin
    if (rst) begin
      fall_s1_r <= 1'b0;
      fall_s2_r <= 1'b0;
      fall_d_r <= 1'b0;
      rise_s1_r <= 1'b0;
      rise_s2_r <= 1'b0;
      rise_d_r <= 1'b0;
    end else begin
      fall_s1_r <= fall_tgl_r;
      fall_s2_r <= fall_s1_r;
      fall_d_r <= fall_s2_r;
      rise_s1_r <= rise_tgl_r;
      rise_s2_r <= rise_s1_r;
      rise_d_r <= rise_s2_r;
    end
  end

  // Named views of the synchronised strobes
  modem_port_pkg::strobes_t stb_now;
  modem_port_pkg::strobes_t stb_old;
  assign stb_now = stb_s2_r;
  assign stb_old = stb_d_r;

  logic ale_fall;
  logic rd_fall;
  logic wr_rise;
  logic bit_fall_evt;
  logic bit_rise_evt;

  // Edge detection on synchronised levels only
  assign ale_fall = stb_old.ale & ~stb_now.ale;
  assign rd_fall = stb_old.rd_n & ~stb_now.rd_n;
  assign wr_rise = ~stb_old.wr_n & stb_now.wr_n;
  assign bit_fall_evt = fall_s2_r ^ fall_d_r;
  assign bit_rise_evt = rise_s2_r ^ rise_d_r;

  // Mode strap caught once after reset release
  logic strap_done_r;
  logic strap_wait_r;
  logic strap_sync_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_mode_r <= 1'b0;
      strap_done_r <= 1'b0;
      strap_wait_r <= 1'b0;
      strap_sync_r <= 1'b0;
    end else begin
      // Wait two cycles; stage two still holds reset levels one cycle after release
      strap_wait_r <= 1'b1;
      strap_sync_r <= strap_wait_r;
      if (strap_sync_r && !strap_done_r) begin
        serial_mode_r <= stb_now.ale & ~stb_now.cs_n;
        strap_done_r <= 1'b1;
      end
    end
  end

  // Parallel address phase
  logic [2:0] lat_addr_r;
  logic lat_cs_n_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      lat_addr_r <= modem_port_pkg::SEL_CTL_ZERO;
      lat_cs_n_r <= 1'b1;
    end else if (ale_fall && !serial_mode_r) begin
      lat_addr_r <= bus_s2_r[modem_port_pkg::SEL_LSB +: modem_port_pkg::SEL_W];
      lat_cs_n_r <= stb_now.cs_n;
    end
  end

  // Active address: serial mode reads the low lines directly
  logic [2:0] ser_sel;
  logic [2:0] act_addr;
  assign ser_sel = bus_s2_r[modem_port_pkg::SEL_LSB +: modem_port_pkg::SEL_W];
  assign act_addr = serial_mode_r ? ser_sel : lat_addr_r;

  // Write request assembly; the serial byte is quasi-static by the strobe rise
  modem_port_pkg::reg_write_t wr_req;
  logic par_wr_ok;
  logic ser_wr_ok;

  assign par_wr_ok = wr_rise & ~serial_mode_r & ~lat_cs_n_r;
  assign ser_wr_ok = wr_rise & serial_mode_r;
  assign wr_req.en = par_wr_ok | ser_wr_ok;
  assign wr_req.addr = act_addr;
  // Parallel data taken one stage late so it lines up with the low strobe
  assign wr_req.data = serial_mode_r ? ser_shift_r : bus_d_r;

  logic [7:0] rd_data_r;

  modem_reg_bank bank_u (
    .mclk(mclk),
    .rst(rst),
    .wr_req(wr_req),
    .rd_addr(act_addr),
    .detect_status(detect_status),
    .rd_data_r(rd_data_r),
    .control_reg_zero_r(control_reg_zero_r),
    .control_reg_one_r(control_reg_one_r),
    .tone_setup_reg_r(tone_setup_reg_r)
  );

  // Serial read engine
  typedef enum logic [1:0] {SR_IDLE, SR_LOAD, SR_SHIFT} sread_t;
  sread_t sr_state_r;
  sread_t sr_state_nxt;
  logic [7:0] rd_word_r;
  logic [2:0] bit_idx_r;
  logic [2:0] bit_idx_nxt;

  // Next state; read strobe high always returns to idle
  always_comb begin
    sr_state_nxt = sr_state_r;
    bit_idx_nxt = bit_idx_r;
    case (sr_state_r)
      SR_IDLE: begin
        if (serial_mode_r && rd_fall) begin
          sr_state_nxt = SR_LOAD;
        end
      end
      SR_LOAD: begin
        bit_idx_nxt = modem_port_pkg::BIT_FIRST;
        sr_state_nxt = stb_now.rd_n ? SR_IDLE : SR_SHIFT;
      end
      SR_SHIFT: begin
        if (stb_now.rd_n) begin
          sr_state_nxt = SR_IDLE;
        end else if (bit_fall_evt && bit_idx_r != modem_port_pkg::BIT_LAST) begin
          bit_idx_nxt = bit_idx_r + modem_port_pkg::BIT_STEP;
        end
      end
      default: begin
        sr_state_nxt = SR_IDLE;
      end
    endcase
  end

  // Read word captured when the engine loads, held for the whole read
  always_ff @(posedge mclk) begin
    if (rst) begin
      sr_state_r <= SR_IDLE;
      bit_idx_r <= modem_port_pkg::BIT_FIRST;
      rd_word_r <= modem_port_pkg::BYTE_ZERO;
    end else begin
      sr_state_r <= sr_state_nxt;
      bit_idx_r <= bit_idx_nxt;
      if (sr_state_r == SR_LOAD) rd_word_r <= rd_data_r;
    end
  end

  // Pin drive selection
  logic par_rd_ok;
  logic ser_rd_ok;
  logic [7:0] bus_out_nxt;
  logic [7:0] bus_oe_nxt;

  assign par_rd_ok = ~serial_mode_r & ~stb_now.rd_n & ~lat_cs_n_r;
  assign ser_rd_ok = serial_mode_r & ~stb_now.rd_n & (sr_state_r == SR_SHIFT);
  assign bus_oe_nxt = par_rd_ok ? modem_port_pkg::BUS_OE_ALL :
                      ser_rd_ok ? modem_port_pkg::BUS_OE_SDATA :
                      modem_port_pkg::BUS_OE_NONE;
  assign bus_out_nxt = par_rd_ok ? rd_data_r :
                       ser_rd_ok ? {rd_word_r[bit_idx_r], 7'h00} :
                       modem_port_pkg::BYTE_ZERO;

  // Registered pin drive; strobes are synchronised, so drive lags by up to 3 mclk, 5 mclk at the start of a serial read
  always_ff @(posedge mclk) begin
    if (rst) begin
      muxed_addr_data_bus_out_r <= modem_port_pkg::BYTE_ZERO;
      muxed_addr_data_bus_oe_r <= modem_port_pkg::BUS_OE_NONE;
    end else begin
      muxed_addr_data_bus_out_r <= bus_out_nxt;
      muxed_addr_data_bus_oe_r <= bus_oe_nxt;
    end
  end

  // Transmit bit hand-off; slot chosen by the parity already seen
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_bit_r <= 1'b0;
      tx_bit_valid_r <= 1'b0;
    end else begin
      tx_bit_valid_r <= bit_rise_evt & ext_timing_sel;
      if (bit_rise_evt && ext_timing_sel) tx_bit_r <= tx_slot_r[rise_d_r];
    end
  end

endmodule : modem_host_register_port

// ---- rtl/modem_port_pkg.sv ----
// Shared constants and carrier types for the modem host register port
package modem_port_pkg;

  // Bus and select widths
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int SYNC_STAGES = 2;

  // Register select codes on the three low lines
  localparam logic [2:0] SEL_CTL_ZERO = 3'h0;
  localparam logic [2:0] SEL_CTL_ONE = 3'h1;
  localparam logic [2:0] SEL_DETECT = 3'h2;
  localparam logic [2:0] SEL_TONE = 3'h3;

  // Line positions when strapped for serial control
  localparam int SDATA_BIT = 7;
  localparam int SEL_LSB = 0;

  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Output enable patterns for the bus lines
  localparam logic [7:0] BUS_OE_NONE = 8'h00;
  localparam logic [7:0] BUS_OE_ALL = 8'hFF;
  localparam logic [7:0] BUS_OE_SDATA = 8'h80;

  // Serial bit index bounds, first bit is the least significant
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_STEP = 3'h1;

  // Host strobes, all active low except the address latch strobe
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } strobes_t;

  // One register write request
  typedef struct packed {
    logic en;
    logic [2:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : modem_port_pkg

// ---- rtl/modem_reg_bank.sv ----
// Four 8-bit host registers with registered read data
`timescale 1ns/10ps

module modem_reg_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire modem_port_pkg::reg_write_t wr_req,
  input wire logic [2:0] rd_addr,
  input wire logic [7:0] detect_status,
  output logic [7:0] rd_data_r,
  output logic [7:0] control_reg_zero_r,
  output logic [7:0] control_reg_one_r,
  output logic [7:0] tone_setup_reg_r
);

  // Match a select code against one register
  function automatic logic hit(input logic [2:0] addr, input logic [2:0] code);
    hit = (addr == code);
  endfunction : hit

  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_tone;
  logic [7:0] rd_data_nxt;

  // Write decode; the detect code has no write strobe, so it stays untouched
  assign wr_ctl0 = wr_req.en & hit(wr_req.addr, modem_port_pkg::SEL_CTL_ZERO);
  assign wr_ctl1 = wr_req.en & hit(wr_req.addr, modem_port_pkg::SEL_CTL_ONE);
  assign wr_tone = wr_req.en & hit(wr_req.addr, modem_port_pkg::SEL_TONE);

  // Read select; unused codes read as zero
  assign rd_data_nxt =
    hit(rd_addr, modem_port_pkg::SEL_CTL_ZERO) ? control_reg_zero_r :
    hit(rd_addr, modem_port_pkg::SEL_CTL_ONE) ? control_reg_one_r :
    hit(rd_addr, modem_port_pkg::SEL_DETECT) ? detect_status :
    hit(rd_addr, modem_port_pkg::SEL_TONE) ? tone_setup_reg_r :
    modem_port_pkg::BYTE_ZERO;

  // Register storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      control_reg_zero_r <= modem_port_pkg::CTL_RESET;
      control_reg_one_r <= modem_port_pkg::CTL_RESET;
      tone_setup_reg_r <= modem_port_pkg::CTL_RESET;
      rd_data_r <= modem_port_pkg::BYTE_ZERO;
    end else begin
      if (wr_ctl0) control_reg_zero_r <= wr_req.data;
      if (wr_ctl1) control_reg_one_r <= wr_req.data;
      if (wr_tone) tone_setup_reg_r <= wr_req.data;
      rd_data_r <= rd_data_nxt;
    end
  end

endmodule : modem_reg_bank

// ---- dv/modem_port_sva.sv ----
// Port rule checker for the modem host register port
`timescale 1ns/10ps
module modem_port_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire modem_port_pkg::strobes_t strobes,
  input wire logic [7:0] muxed_addr_data_bus_oe_r,
  input wire logic ext_timing_sel,
  input wire logic tx_bit_valid_r,
  input wire logic serial_mode_r,
  input wire logic [7:0] control_reg_zero_r,
  input wire logic [7:0] control_reg_one_r,
  input wire logic [7:0] tone_setup_reg_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [3:0] age_r;
  logic [3:0] age_nxt;
  wire logic [7:0] oe = muxed_addr_data_bus_oe_r;
  wire logic [23:0] regs = {control_reg_zero_r, control_reg_one_r, tone_setup_reg_r};
  // Cycles since reset, saturating so the strap check stays cheap
  assign age_nxt = rst ? 4'h0 : ((age_r == 4'hF) ? age_r : age_r + 4'h1);
  always_ff @(posedge mclk) age_r <= age_nxt;
  sequence s_ser_rd;
    (serial_mode_r && !strobes.rd_n)[*6];
  endsequence
  property p_idle; strobes.rd_n[*5] |-> oe == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("bus driven with read idle");
  property p_ser_oe; s_ser_rd |-> oe == 8'h80; endproperty
  a_ser_oe: assert property (p_ser_oe) else $error("serial read not on top line");
  property p_par_oe; (!serial_mode_r && !strobes.rd_n)[*6] |-> oe inside {8'h00, 8'hFF};
  endproperty
  a_par_oe: assert property (p_par_oe) else $error("partial bus drive");
  property p_oe_mode; oe == 8'h80 |-> serial_mode_r; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("top line alone in parallel");
  property p_strap; age_r == 4'h4 |-> serial_mode_r == (strobes.ale && !strobes.cs_n); endproperty
  a_strap: assert property (p_strap) else $error("strap mode wrong");
  property p_mode_hold; age_r == 4'hF |-> $stable(serial_mode_r); endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_tx_off; (!ext_timing_sel)[*6] |-> !tx_bit_valid_r; endproperty
  a_tx_off: assert property (p_tx_off) else $error("sample with timing off");
  property p_tx_pulse; tx_bit_valid_r |=> !tx_bit_valid_r; endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("sample pulse too long");
  property p_reg_cause;
    $changed(regs) |-> strobes.wr_n && (!$past(strobes.wr_n, 4) || !$past(strobes.wr_n, 5));
  endproperty
  a_reg_cause: assert property (p_reg_cause) else $error("store without strobe rise");
endmodule : modem_port_sva

// ---- dv/host_model.sv ----
// Host controller model driving the register port pins
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  input wire logic [7:0] oe,
  input wire logic [7:0] dout,
  output modem_port_pkg::strobes_t s,
  output logic [7:0] bus,
  output logic ebc
);
  logic [7:0] hv;
  // Wire level; released host lines show the inverse of their last value
  assign bus = (oe & dout) | (~oe & hv);
  initial begin
    s = 4'h7;
    hv = 8'h00;
    ebc = 1'h1;
  end
  task automatic w(input int n); repeat (n) @(posedge mclk); endtask : w
  // Bit clock idles high; off-grid start keeps it unrelated to mclk
  task automatic ck(input int n);
    #7;
    repeat (n) begin
      #32 ebc = 1'h0;
      #32 ebc = 1'h1;
    end
  endtask : ck
  task automatic strap(input logic ser); s <= {ser, ~ser, 2'h3}; endtask : strap
  // Parallel cycle: latch address and select, then one strobe
  task automatic pa(input logic [2:0] a, input logic cs, input logic rd,
                    inout logic [7:0] d, output logic [7:0] o);
    w(1); s.ale <= 1'h1; s.cs_n <= cs; hv <= {5'h00, a};
    w(3); s.ale <= 1'h0;
    w(3);
    if (rd) begin hv <= ~hv; s.rd_n <= 1'h0; end else begin hv <= d; s.wr_n <= 1'h0; end
    w(7); d = rd ? bus : d; o = oe;
    s.rd_n <= 1'h1; s.wr_n <= 1'h1;
    w(2); hv <= ~hv; w(6);
  endtask : pa
  // Serial cycle; select lines held for the whole access
  task automatic sa(input logic [2:0] a, input logic rd, inout logic [7:0] d,
                    output logic [7:0] o);
    w(1); hv[2:0] <= a; w(2);
    if (rd) begin
      s.rd_n <= 1'h0; w(8); o = oe;
      for (int i = 0; i < 8; i++) begin d[i] = bus[7]; ck(1); w(4); end
      s.rd_n <= 1'h1;
    end else begin
      for (int i = 0; i < 8; i++) begin hv[7] <= d[i]; w(1); ck(1); w(1); end
      w(3); s.wr_n <= 1'h0; w(4); s.wr_n <= 1'h1;
    end
    w(6); hv <= ~hv;
  endtask : sa
endmodule : host_model

// ---- dv/tb.sv ----
// Self-checking bench for the modem host register port
`timescale 1ns/10ps
module tb;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic ext_timing_sel = 1'h0;
  logic tx_data_in = 1'h0;
  logic [7:0] detect_status = 8'h00;
  logic ebc, serial_mode_r, tx_bit_r, tx_bit_valid_r;
  logic [7:0] bus, dout, oe, r0, r1, r3, d, o;
  modem_port_pkg::strobes_t s;
  int n_errors = 0;
  int cmp_count = 0;
  int nv = 0;
  int ex[4] = '{0, 0, 0, 0};
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
  always #20 mclk = ~mclk;
  modem_host_register_port uut (.mclk, .rst, .external_bit_clock(ebc), .strobes(s),
    .muxed_addr_data_bus_in(bus), .muxed_addr_data_bus_out_r(dout),
    .muxed_addr_data_bus_oe_r(oe), .detect_status, .ext_timing_sel, .tx_data_in,
    .tx_bit_r, .tx_bit_valid_r, .serial_mode_r, .control_reg_zero_r(r0),
    .control_reg_one_r(r1), .tone_setup_reg_r(r3));
  host_model hm (.mclk, .oe, .dout, .s, .bus, .ebc);
  // Each transmit sample must carry the bit held at the clock rise
  always @(posedge mclk) if (tx_bit_valid_r === 1'h1) begin
    nv <= nv + 1;
    `CHK(tx_bit_r, tx_data_in)
  end
  task automatic finish_test;
    $display("checks=%0d errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // Bit clock ticks during and just after reset, else the link reset never lifts
  task automatic rs(input logic ser);
    @(posedge mclk) rst <= 1'h1;
    hm.strap(ser);
    hm.ck(2);
    @(posedge mclk) rst <= 1'h0;
    hm.ck(2);
    repeat (8) @(posedge mclk);
  endtask : rs
  task automatic regs_chk;
    `CHK({r0, r1, r3}, {ex[0][7:0], ex[1][7:0], ex[3][7:0]})
  endtask : regs_chk
  initial begin
    void'($urandom(99055));
    detect_status = 8'($urandom);
    ex[2] = detect_status;
    rs(1'h0);
    `CHK({r0, r1, r3, serial_mode_r}, 25'h0)
    for (int a = 0; a < 4; a++) begin
      d = 8'($urandom);
      hm.pa(a[2:0], 1'h0, 1'h0, d, o);
      if (a != 2) ex[a] = d;
    end
    d = 8'($urandom);
    hm.pa(3'h1, 1'h1, 1'h0, d, o);
    regs_chk();
    for (int a = 0; a < 4; a++) begin
      hm.pa(a[2:0], 1'h0, 1'h1, d, o);
      `CHK(d, ex[a][7:0])
      `CHK(o, 8'hFF)
    end
    hm.pa(3'h0, 1'h1, 1'h1, d, o);
    `CHK(o, 8'h00)
    rs(1'h1);
    `CHK(serial_mode_r, 1'h1)
    for (int a = 0; a < 4; a++) begin
      d = 8'($urandom);
      hm.sa(a[2:0], 1'h0, d, o);
      if (a != 2) ex[a] = d;
    end
    regs_chk();
    for (int a = 0; a < 4; a++) begin
      hm.sa(a[2:0], 1'h1, d, o);
      `CHK(d, ex[a][7:0])
      `CHK(o, 8'h80)
    end
    for (int k = 0; k < 16; k++) begin
      @(posedge mclk) ext_timing_sel <= (k >= 8);
      tx_data_in <= 1'($urandom);
      hm.ck(1);
      repeat (5) @(posedge mclk);
    end
    `CHK(nv, 8)
    finish_test();
  end
  // Cut a hang short well past the expected run length
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
endmodule : tb
bind modem_host_register_port modem_port_sva chk (.mclk, .rst, .strobes,
  .muxed_addr_data_bus_oe_r, .ext_timing_sel, .tx_bit_valid_r, .serial_mode_r,
  .control_reg_zero_r, .control_reg_one_r, .tone_setup_reg_r);
